// [pms_pkg.sv]
// constants shared by the plotter motion-support logic
package pms_pkg;
	// ==========================================================
	// clocking and timing
	localparam int OSC_HZ = 12_000_000;
	localparam int PHASE_HZ = 4_000_000;
	localparam int OSC_DIV = OSC_HZ / PHASE_HZ;
	localparam logic [1:0] PH_LAST = 2'(OSC_DIV - 1);
	localparam logic [1:0] PH_A = 2'h0;
	localparam logic [1:0] PH_B = 2'h1;
	localparam int START_PERIOD_US = 64100;
	localparam int START_TICKS = START_PERIOD_US * (PHASE_HZ / 1_000_000);
	localparam int TRACK_HZ = 977;
	localparam int TRACK_TICKS = PHASE_HZ / TRACK_HZ;
	localparam int TRACK_DIV_W = 12;
	// ==========================================================
	// widths
	localparam int DATA_W = 8;
	localparam int POS_W = 16;
	localparam int MAG_W = 7;
	localparam int SIGN_BIT = 7;
	localparam int N_DRIVE = 4;
	localparam int N_AXIS = 2;
	localparam int N_PWM = 3;
	localparam int SUB_LSB = 0;
	localparam int STEP_LSB = 4;
	localparam logic [3:0] QUARTER = 4'h4;
	// ==========================================================
	// function codes latched on the address strobe
	localparam logic [7:0] FN_PWM_PAPER = 8'h00;
	localparam logic [7:0] FN_PWM_CARR = 8'h01;
	localparam logic [7:0] FN_PEN_ACT = 8'h02;
	localparam logic [7:0] FN_PEN_HOLD = 8'h03;
	localparam logic [7:0] FN_POS_PAPER_LO = 8'h10;
	localparam logic [7:0] FN_POS_PAPER_HI = 8'h11;
	localparam logic [7:0] FN_POS_CARR_LO = 8'h12;
	localparam logic [7:0] FN_POS_CARR_HI = 8'h13;
	localparam logic [7:0] FN_TRACK = 8'h20;
	localparam logic [7:0] FN_COMPARE_ENABLE = 8'h21;
	// ==========================================================
	// reset values and tracking counter limit
	localparam logic [7:0] TRACK_RESET = 8'h00;
	localparam logic [7:0] TRACK_MAX = 8'hff;
	localparam logic COMPARE_ENABLE_RESET = 1'b1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage

// [pms_motion_support.sv]
// motion-support logic: bus decode, clocks, encoder, pwm and tracking
//
// Behaviour
// (RULE_01) count between feedback zero crossings, load register
// (RULE_02) separate paper and carriage position registers
// (RULE_03) processor reads both positions every cycle
// (RULE_04) pen drive has actuate and hold levels
// (RULE_05) tracking counter samples comparator, counts up/down
// (RULE_06) supply reference pwm follows tracking counter
// (RULE_07) processor scales drive values by tracking gain
// (RULE_08) respond only when A13 is high
// (RULE_09) function code latched on latch-enable strobe
// (RULE_10) decode function code to internal section
// (RULE_11) divide 12 MHz into two 4 MHz phases
// (RULE_12) parallel variant drives 4 MHz interface clock
// (RULE_13) free-running counter addresses sine table
// (RULE_14) start pulse to all pwms every 64.1 ms
// (RULE_15) 977 Hz tick paces tracking converter
// (RULE_16) four sine pwm drives, 90 degrees apart
// (RULE_17) three identical pwm units
// (RULE_18) all outputs inactive while reset held
// (RULE_19) processor multiplexes low address and data
// (RULE_20) magnitude sets width, sign picks output
// (RULE_21) tracking counter cleared, counts when enabled
// (RULE_22) unselected axis output held low
// (RULE_23) feedback synchronised before edge detection
`timescale 1ns/1ps
module pms_motion_support #(
	parameter int START_TICKS_P = pms_pkg::START_TICKS
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_osc_12m,
	input wire logic i_parallel_variant,
	input wire logic i_ale,
	input wire logic i_a13,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [pms_pkg::DATA_W-1:0] i_muxed_addr_data,
	output logic [pms_pkg::DATA_W-1:0] o_muxed_addr_data,
	output logic o_muxed_addr_data_oe,
	output logic o_clk4_a,
	output logic o_clk4_b,
	output logic o_ieee_clk,
	output logic [pms_pkg::N_DRIVE-1:0] o_encoder_drive,
	input wire logic i_paper_axis_feedback,
	input wire logic i_carriage_axis_feedback,
	output logic o_paper_motor_out_fwd,
	output logic o_paper_motor_out_rev,
	output logic o_carriage_motor_out_fwd,
	output logic o_carriage_motor_out_rev,
	output logic o_pen_drive,
	output logic o_pen_actuating,
	input wire logic i_supply_compare_in,
	output logic o_supply_ref_pwm,
	output logic o_pwm_start,
	output logic o_track_tick
);
	import pms_pkg::*;

	localparam int SW = $clog2(START_TICKS_P + 1);
	localparam logic [SW-1:0] START_LAST = SW'(START_TICKS_P - 1);
	localparam logic [TRACK_DIV_W-1:0] TRACK_LAST = TRACK_DIV_W'(TRACK_TICKS - 1);

	// ==========================================================
	// phase generator
	logic osc_q;
	logic [1:0] ph_q;
	logic clk4_a_q;
	logic clk4_b_q;
	logic ieee_q;
	wire osc_rise = i_osc_12m & ~osc_q;
	wire tick = osc_rise & (ph_q == PH_LAST);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin // RULE_18
			osc_q <= 1'b0;
			ph_q <= 2'h0;
			clk4_a_q <= 1'b0;
			clk4_b_q <= 1'b0;
			ieee_q <= 1'b0;
		end else begin
			osc_q <= i_osc_12m;
			if (osc_rise) begin
				ph_q <= (ph_q == PH_LAST) ? 2'h0 : ph_q + 2'h1; // RULE_11
			end
			clk4_a_q <= (ph_q == PH_A); // RULE_11
			clk4_b_q <= (ph_q == PH_B); // RULE_11
			ieee_q <= i_parallel_variant & (ph_q == PH_A); // RULE_12
		end
	end

	// ==========================================================
	// position counter, start pulse and tracking tick
	logic [SW-1:0] pos_q;
	logic [TRACK_DIV_W-1:0] tdiv_q;
	logic start_q;
	logic ttick_q;
	wire pos_wrap = (pos_q == START_LAST);
	wire tdiv_wrap = (tdiv_q == TRACK_LAST);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pos_q <= '0;
			tdiv_q <= '0;
			start_q <= 1'b0;
			ttick_q <= 1'b0;
		end else begin
			if (tick) begin
				pos_q <= pos_wrap ? '0 : pos_q + SW'(1); // RULE_13
				tdiv_q <= tdiv_wrap ? '0 : tdiv_q + TRACK_DIV_W'(1);
			end
			start_q <= tick & pos_wrap; // RULE_14
			ttick_q <= tick & tdiv_wrap; // RULE_15
		end
	end

	// ==========================================================
	// sine generator
	function automatic logic [3:0] sine_lvl(input logic [3:0] a);
		case (a)
			4'h0: sine_lvl = 4'h8;
			4'h1: sine_lvl = 4'hb;
			4'h2: sine_lvl = 4'hd;
			4'h3: sine_lvl = 4'hf;
			4'h4: sine_lvl = 4'hf;
			4'h5: sine_lvl = 4'hf;
			4'h6: sine_lvl = 4'hd;
			4'h7: sine_lvl = 4'hb;
			4'h8: sine_lvl = 4'h8;
			4'h9: sine_lvl = 4'h5;
			4'ha: sine_lvl = 4'h3;
			4'hb: sine_lvl = 4'h1;
			4'hc: sine_lvl = 4'h1;
			4'hd: sine_lvl = 4'h1;
			4'he: sine_lvl = 4'h3;
			default: sine_lvl = 4'h5;
		endcase
	endfunction

	wire [3:0] sine_step = pos_q[STEP_LSB +: 4];
	wire [3:0] sine_sub = pos_q[SUB_LSB +: 4];
	logic [N_DRIVE-1:0] drive_q;
	for (genvar k = 0; k < N_DRIVE; k++) begin : g_drive
		wire [3:0] addr = sine_step + 4'(k) * QUARTER; // RULE_16
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				drive_q[k] <= 1'b0;
			end else begin
				drive_q[k] <= sine_sub < sine_lvl(addr); // RULE_16
			end
		end
	end

	// ==========================================================
	// encoder phase measurement
	wire [N_AXIS-1:0] fb_in = {i_carriage_axis_feedback, i_paper_axis_feedback};
	logic [N_AXIS-1:0] fb_s1_q;
	logic [N_AXIS-1:0] fb_s2_q;
	logic [N_AXIS-1:0] fb_d_q;
	logic [POS_W-1:0] pcnt_q [N_AXIS];
	logic [POS_W-1:0] posreg_q [N_AXIS];
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fb_s1_q <= '0;
			fb_s2_q <= '0;
			fb_d_q <= '0;
		end else begin
			fb_s1_q <= fb_in; // RULE_23
			fb_s2_q <= fb_s1_q; // RULE_23
			fb_d_q <= fb_s2_q;
		end
	end

	for (genvar a = 0; a < N_AXIS; a++) begin : g_axis
		wire zc = fb_s2_q[a] & ~fb_d_q[a];
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				pcnt_q[a] <= '0;
				posreg_q[a] <= '0;
			end else if (zc) begin
				posreg_q[a] <= pcnt_q[a]; // RULE_01 RULE_02
				pcnt_q[a] <= '0; // RULE_01
			end else if (tick) begin
				pcnt_q[a] <= pcnt_q[a] + POS_W'(1); // RULE_01
			end
		end
	end

	// ==========================================================
	// bus interface and decode
	logic [DATA_W-1:0] fn_q;
	logic sel_q;
	logic wr_prev_q;
	logic [DATA_W-1:0] ad_out_q;
	logic ad_oe_q;
	wire wr_pulse = sel_q & ~i_ale & ~i_wr_n & wr_prev_q; // RULE_08
	wire wr_paper = wr_pulse & (fn_q == FN_PWM_PAPER); // RULE_10
	wire wr_carr = wr_pulse & (fn_q == FN_PWM_CARR); // RULE_10
	wire wr_act = wr_pulse & (fn_q == FN_PEN_ACT); // RULE_10
	wire wr_hold = wr_pulse & (fn_q == FN_PEN_HOLD); // RULE_10
	wire wr_compare_enable = wr_pulse & (fn_q == FN_COMPARE_ENABLE); // RULE_10
	logic [DATA_W-1:0] trk_q;
	logic compare_enable_q;
	logic [DATA_W-1:0] rd_data;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (fn_q) // RULE_10
			FN_POS_PAPER_LO: rd_data = posreg_q[0][7:0];
			FN_POS_PAPER_HI: rd_data = posreg_q[0][15:8];
			FN_POS_CARR_LO: rd_data = posreg_q[1][7:0];
			FN_POS_CARR_HI: rd_data = posreg_q[1][15:8];
			FN_TRACK: rd_data = trk_q;
			FN_COMPARE_ENABLE: rd_data = {7'h00, compare_enable_q};
			default: begin
				rd_data = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fn_q <= 8'h00;
			sel_q <= 1'b0;
			wr_prev_q <= 1'b1;
			ad_out_q <= 8'h00;
			ad_oe_q <= 1'b0;
		end else begin
			if (i_ale) begin
				fn_q <= i_muxed_addr_data; // RULE_09
				sel_q <= i_a13; // RULE_08
			end
			wr_prev_q <= i_wr_n;
			ad_out_q <= rd_data;
			ad_oe_q <= sel_q & ~i_ale & ~i_rd_n & rd_hit; // RULE_08
		end
	end

	// ==========================================================
	// control values written by the processor
	logic [DATA_W-1:0] ctrl_q [N_AXIS];
	logic [DATA_W-1:0] pen_act_q;
	logic [DATA_W-1:0] pen_hold_q;
	logic pen_mode_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_q[0] <= CTRL_RESET;
			ctrl_q[1] <= CTRL_RESET;
			pen_act_q <= CTRL_RESET;
			pen_hold_q <= CTRL_RESET;
			pen_mode_q <= 1'b0;
			compare_enable_q <= COMPARE_ENABLE_RESET;
		end else begin
			if (wr_paper) begin
				ctrl_q[0] <= i_muxed_addr_data;
			end
			if (wr_carr) begin
				ctrl_q[1] <= i_muxed_addr_data;
			end
			if (wr_act) begin
				pen_act_q <= i_muxed_addr_data; // RULE_04
				pen_mode_q <= 1'b1; // RULE_04
			end
			if (wr_hold) begin
				pen_hold_q <= i_muxed_addr_data; // RULE_04
				pen_mode_q <= 1'b0; // RULE_04
			end
			if (wr_compare_enable) begin
				compare_enable_q <= i_muxed_addr_data[0];
			end
		end
	end

	// ==========================================================
	// three pwm units
	wire [DATA_W-1:0] pen_lvl = pen_mode_q ? pen_act_q : pen_hold_q; // RULE_04
	wire [DATA_W-1:0] pwm_val [N_PWM];
	assign pwm_val[0] = ctrl_q[0];
	assign pwm_val[1] = ctrl_q[1];
	assign pwm_val[2] = {1'b0, pen_lvl[MAG_W-1:0]}; // RULE_20
	logic [MAG_W-1:0] pw_cnt_q [N_PWM];
	logic [N_PWM-1:0] pw_sign_q;
	logic [N_PWM-1:0] pw_on;
	for (genvar p = 0; p < N_PWM; p++) begin : g_pwm
		assign pw_on[p] = (pw_cnt_q[p] != '0);
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				pw_cnt_q[p] <= '0;
				pw_sign_q[p] <= 1'b0;
			end else if (start_q) begin
				pw_cnt_q[p] <= pwm_val[p][MAG_W-1:0]; // RULE_17 RULE_20
				pw_sign_q[p] <= pwm_val[p][SIGN_BIT]; // RULE_20
			end else if (tick & pw_on[p]) begin
				pw_cnt_q[p] <= pw_cnt_q[p] - MAG_W'(1); // RULE_17
			end
		end
	end

	logic paper_fwd_q;
	logic paper_rev_q;
	logic carr_fwd_q;
	logic carr_rev_q;
	logic pen_q;
	logic pen_act_out_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			paper_fwd_q <= 1'b0;
			paper_rev_q <= 1'b0;
			carr_fwd_q <= 1'b0;
			carr_rev_q <= 1'b0;
			pen_q <= 1'b0;
			pen_act_out_q <= 1'b0;
		end else begin
			paper_fwd_q <= pw_on[0] & ~pw_sign_q[0]; // RULE_20 RULE_22
			paper_rev_q <= pw_on[0] & pw_sign_q[0]; // RULE_20 RULE_22
			carr_fwd_q <= pw_on[1] & ~pw_sign_q[1]; // RULE_20 RULE_22
			carr_rev_q <= pw_on[1] & pw_sign_q[1]; // RULE_20 RULE_22
			pen_q <= pw_on[2];
			pen_act_out_q <= pen_mode_q;
		end
	end

	// ==========================================================
	// supply tracking converter
	logic samp_q;
	logic samp_v_q;
	logic supply_ref_pwm_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			samp_q <= 1'b0;
			samp_v_q <= 1'b0;
			trk_q <= TRACK_RESET; // RULE_21
			supply_ref_pwm_q <= 1'b0;
		end else begin
			samp_v_q <= ttick_q & compare_enable_q; // RULE_05 RULE_21
			if (ttick_q & compare_enable_q) begin
				samp_q <= i_supply_compare_in; // RULE_05
			end
			if (samp_v_q & samp_q & (trk_q != TRACK_MAX)) begin
				trk_q <= trk_q + 8'h01; // RULE_05
			end else if (samp_v_q & ~samp_q & (trk_q != TRACK_RESET)) begin
				trk_q <= trk_q - 8'h01; // RULE_05
			end
			supply_ref_pwm_q <= pos_q[7:0] < trk_q; // RULE_06
		end
	end

	// ==========================================================
	// outputs
	assign o_muxed_addr_data = ad_out_q;
	assign o_muxed_addr_data_oe = ad_oe_q;
	assign o_clk4_a = clk4_a_q;
	assign o_clk4_b = clk4_b_q;
	assign o_ieee_clk = ieee_q;
	assign o_encoder_drive = drive_q;
	assign o_paper_motor_out_fwd = paper_fwd_q;
	assign o_paper_motor_out_rev = paper_rev_q;
	assign o_carriage_motor_out_fwd = carr_fwd_q;
	assign o_carriage_motor_out_rev = carr_rev_q;
	assign o_pen_drive = pen_q;
	assign o_pen_actuating = pen_act_out_q;
	assign o_supply_ref_pwm = supply_ref_pwm_q;
	assign o_pwm_start = start_q;
	assign o_track_tick = ttick_q;
endmodule

// [pms_assertions.sv]
// assertions on the motion-support block ports
`timescale 1ns/1ps
module pms_assertions (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_rd_n,
	input wire logic o_muxed_addr_data_oe,
	input wire logic o_clk4_a,
	input wire logic o_clk4_b,
	input wire logic o_ieee_clk,
	input wire logic [pms_pkg::N_DRIVE-1:0] o_encoder_drive,
	input wire logic o_paper_motor_out_fwd,
	input wire logic o_paper_motor_out_rev,
	input wire logic o_carriage_motor_out_fwd,
	input wire logic o_carriage_motor_out_rev,
	input wire logic o_pen_drive,
	input wire logic o_pwm_start,
	input wire logic o_track_tick
);
	// ==========================================================
	// properties
	phase_order_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_clk4_a) |-> $rose(o_clk4_b)) else $error("phase b not after phase a");
	ieee_copy_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_ieee_clk |-> (o_clk4_a || $past(o_clk4_a))) else $error("ieee clock off phase");
	paper_excl_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!(o_paper_motor_out_fwd && o_paper_motor_out_rev)) else $error("paper both on");
	carr_excl_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!(o_carriage_motor_out_fwd && o_carriage_motor_out_rev)) else $error("carriage both on");
	start_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_pwm_start |=> !o_pwm_start [*8]) else $error("start pulse too long");
	track_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_track_tick |=> !o_track_tick [*8]) else $error("track tick too long");
	read_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_muxed_addr_data_oe) |-> !$past(i_rd_n)) else $error("bus driven unasked");
	read_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rd_n && $past(i_rd_n)) |-> !o_muxed_addr_data_oe) else $error("bus not released");
	reset_quiet_a: assert property (@(posedge i_clk) i_rst |=>
		(o_encoder_drive == 4'h0 && !o_pen_drive && !o_pwm_start && !o_muxed_addr_data_oe))
		else $error("output active in reset");
	read_c: cover property (@(posedge i_clk) $rose(o_muxed_addr_data_oe));
	start_c: cover property (@(posedge i_clk) o_pwm_start);
	pen_c: cover property (@(posedge i_clk) $rose(o_pen_drive));
endmodule
bind pms_motion_support pms_assertions CHK (.i_clk(i_clk), .i_rst(i_rst), .i_rd_n(i_rd_n),
	.o_muxed_addr_data_oe(o_muxed_addr_data_oe), .o_clk4_a(o_clk4_a), .o_clk4_b(o_clk4_b),
	.o_ieee_clk(o_ieee_clk), .o_encoder_drive(o_encoder_drive),
	.o_paper_motor_out_fwd(o_paper_motor_out_fwd), .o_paper_motor_out_rev(o_paper_motor_out_rev),
	.o_carriage_motor_out_fwd(o_carriage_motor_out_fwd),
	.o_carriage_motor_out_rev(o_carriage_motor_out_rev), .o_pen_drive(o_pen_drive),
	.o_pwm_start(o_pwm_start), .o_track_tick(o_track_tick));

// [pms_encoder_model.sv]
// encoder model: square feedback whose period sets the position count
`timescale 1ns/1ps
module pms_encoder_model #(
	parameter int HALF_P = 240,
	parameter int HALF_C = 342
) (
	input wire logic i_clk,
	input wire logic i_rst,
	output logic o_paper,
	output logic o_carriage
);
	int np;
	int nc;
	// ==========================================================
	// each axis toggles at its own half period
	always @(posedge i_clk) begin
		np <= (i_rst || np == HALF_P - 1) ? 0 : np + 1;
		nc <= (i_rst || nc == HALF_C - 1) ? 0 : nc + 1;
		o_paper <= i_rst ? 1'b0 : (np == HALF_P - 1) ? ~o_paper : o_paper;
		o_carriage <= i_rst ? 1'b0 : (nc == HALF_C - 1) ? ~o_carriage : o_carriage;
	end
endmodule

// [plotter_motion_support_logic_tb.sv]
// testbench for the motion-support block
`timescale 1ns/1ps
module plotter_motion_support_logic_tb;
	import pms_pkg::*;
	logic i_clk, i_rst, osc, pvar, ale, a13, rd_n, wr_n, cmpin;
	logic [7:0] ad, rdat;
	logic oe, ca, cb, ieee, pst, tt, pf, pr, cf, cr, pen, act, refp, fbp, fbc;
	logic [3:0] drv;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	pms_motion_support #(.START_TICKS_P(300)) DUT (.i_clk(i_clk), .i_rst(i_rst),
		.i_osc_12m(osc), .i_parallel_variant(pvar), .i_ale(ale), .i_a13(a13), .i_rd_n(rd_n),
		.i_wr_n(wr_n), .i_muxed_addr_data(ad), .o_muxed_addr_data(rdat),
		.o_muxed_addr_data_oe(oe), .o_clk4_a(ca), .o_clk4_b(cb), .o_ieee_clk(ieee),
		.o_encoder_drive(drv), .i_paper_axis_feedback(fbp), .i_carriage_axis_feedback(fbc),
		.o_paper_motor_out_fwd(pf), .o_paper_motor_out_rev(pr), .o_carriage_motor_out_fwd(cf),
		.o_carriage_motor_out_rev(cr), .o_pen_drive(pen), .o_pen_actuating(act),
		.i_supply_compare_in(cmpin), .o_supply_ref_pwm(refp), .o_pwm_start(pst),
		.o_track_tick(tt));
	pms_encoder_model #(.HALF_P(240), .HALF_C(342)) ENC (.i_clk(i_clk), .i_rst(i_rst),
		.o_paper(fbp), .o_carriage(fbc));
	// ==========================================================
	// clock, sped-up oscillator (one phase tick per 12 cycles) and timeout
	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	always @(negedge i_clk) begin
		cyc <= cyc + 1;
		osc <= cyc[1];
		if (cyc == 90000) begin
			miscompares++;
			test_done();
		end
	end
	// ==========================================================
	// shared tasks
	task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] c, logic [7:0] d);
		@(negedge i_clk) {ale, a13, ad} = {2'b11, c};
		@(negedge i_clk) {ale, ad, wr_n} = {1'b0, d, 1'b0};
		@(negedge i_clk) wr_n = 1;
	endtask
	task automatic rd(logic [7:0] c, logic sel, logic eoe, logic [7:0] e, string n);
		@(negedge i_clk) {ale, a13, ad} = {1'b1, sel, c};
		@(negedge i_clk) {ale, rd_n} = 2'b00;
		repeat (2) @(negedge i_clk);
		cmp({n, " oe"}, 16'(eoe), 16'(oe));
		if (eoe) cmp(n, 16'(e), 16'(rdat));
		@(negedge i_clk) rd_n = 1;
		repeat (2) @(negedge i_clk);
		cmp({n, " release"}, 16'h0, 16'(oe));
	endtask
	task automatic test_done;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs;
		rd(FN_TRACK, 1, 1, TRACK_RESET, "track reset");
		rd(FN_COMPARE_ENABLE, 1, 1, 8'h01, "compare_enable reset");
		rd(FN_COMPARE_ENABLE, 0, 0, 8'h00, "deselected");
		rd(8'h7f, 1, 0, 8'h00, "unmapped");
		wr(FN_COMPARE_ENABLE, 8'h00);
		rd(FN_COMPARE_ENABLE, 1, 1, 8'h00, "compare_enable off");
		wr(FN_COMPARE_ENABLE, 8'h01);
		rd(FN_COMPARE_ENABLE, 1, 1, 8'h01, "compare_enable on");
	endtask
	task automatic t_enc;
		repeat (1500) @(negedge i_clk);
		rd(FN_POS_PAPER_LO, 1, 1, 8'd40, "paper lo");
		rd(FN_POS_PAPER_HI, 1, 1, 8'h00, "paper hi");
		rd(FN_POS_CARR_LO, 1, 1, 8'd57, "carriage lo");
		rd(FN_POS_CARR_HI, 1, 1, 8'h00, "carriage hi");
	endtask
	task automatic t_pwm;
		int n[5];
		int k;
		n = '{default: 0};
		wr(FN_PWM_PAPER, 8'h85);
		wr(FN_PWM_CARR, 8'h03);
		wr(FN_PEN_ACT, 8'h04);
		for (k = 0; k < 5000 && !pst; k++) @(negedge i_clk);
		@(negedge i_clk);
		for (k = 1; k < 5000 && !pst; k++) @(negedge i_clk);
		cmp("start spacing", 16'd3600, 16'(k));
		repeat (1000) @(negedge i_clk) begin
			n[0] += pf;
			n[1] += pr;
			n[2] += cf;
			n[3] += cr;
			n[4] += pen;
		end
		cmp("paper fwd", 16'd0, 16'(n[0]));
		// 12 cycles a tick; the first tick after the start pulse is one cycle short
		cmp("paper rev", 16'd59, 16'(n[1]));
		cmp("carriage fwd", 16'd35, 16'(n[2]));
		cmp("carriage rev", 16'd0, 16'(n[3]));
		cmp("pen width", 16'd47, 16'(n[4]));
		cmp("actuate", 16'd1, 16'(act));
		wr(FN_PEN_HOLD, 8'h02);
		repeat (2) @(negedge i_clk);
		cmp("hold", 16'd0, 16'(act));
		for (k = 0; k < 5000 && !pst; k++) @(negedge i_clk);
		n[4] = 0;
		repeat (1000) @(negedge i_clk) n[4] += pen;
		cmp("pen hold width", 16'd23, 16'(n[4]));
	endtask
	task automatic t_clocks;
		int n[4];
		n = '{default: 0};
		// two ticks: each phase stands four of the twelve cycles
		repeat (24) @(negedge i_clk) begin
			n[0] += ca;
			n[1] += cb;
			n[2] += ieee;
		end
		pvar = 0;
		repeat (24) @(negedge i_clk) n[3] += ieee;
		pvar = 1;
		cmp("phase a", 16'd8, 16'(n[0]));
		cmp("phase b", 16'd8, 16'(n[1]));
		cmp("interface clock", 16'd8, 16'(n[2]));
		cmp("interface clock off", 16'd0, 16'(n[3]));
	endtask
	task automatic t_sine;
		int n[4];
		int k;
		n = '{default: 0};
		for (k = 0; k < 5000 && !pst; k++) @(negedge i_clk);
		// one full sine cycle: 256 counter steps of 12 cycles, mid-scale on average
		repeat (3072) @(negedge i_clk) begin
			for (k = 0; k < 4; k++) n[k] += drv[k];
		end
		for (k = 0; k < 4; k++) cmp("drive duty", 16'd1536, 16'(n[k]));
	endtask
	task automatic t_track;
		int k;
		int n;
		n = 0;
		for (k = 0; k < 60000 && !tt; k++) @(negedge i_clk);
		repeat (3) @(negedge i_clk);
		rd(FN_TRACK, 1, 1, 8'h01, "track up");
		// count of one: low byte zero at two of the 300 counter steps
		repeat (3600) @(negedge i_clk) n += refp;
		cmp("supply ref width", 16'd24, 16'(n));
	endtask
	initial begin
		{ale, a13, ad} = '0;
		{i_rst, pvar, rd_n, wr_n, cmpin} = 5'h1f;
		repeat (10) @(negedge i_clk);
		cmp("drive in reset", 16'h0, 16'(drv));
		cmp("ref in reset", 16'h0, 16'(refp));
		i_rst = 0;
		t_regs();
		t_clocks();
		t_enc();
		t_pwm();
		t_sine();
		t_track();
		test_done();
	end
endmodule
